// ===== rtl/soft_cpu_pkg.sv
package soft_cpu_pkg;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam int FLD_A_LSB = 0;
  localparam int FLD_B_LSB = 4;
  localparam int FLD_CONST_LSB = 4;
  localparam int FLD_COND_LSB = 9;
  localparam int FLD_OFFSET_LSB = 8;
  localparam int FLD_PORT_LSB = 4;
  localparam int FLD_LOOP_BIT = 8;
  localparam int FLD_REP_BIT = 11;
  localparam int FLD_PUSH_REGISTER_BIT = 10;

  localparam logic [1:0] TYPE_CALL = 2'h0;
  localparam logic [1:0] TYPE_FLOW = 2'h1;
  localparam logic [1:0] TYPE_IMM = 2'h2;
  localparam logic [1:0] TYPE_REG = 2'h3;

  localparam logic [1:0] FLOW_JUMP = 2'h0;
  localparam logic [1:0] FLOW_RET = 2'h1;
  localparam logic [1:0] FLOW_PUSH = 2'h2;
  localparam logic [1:0] FLOW_LOAD = 2'h3;

  localparam logic [1:0] IMM_ADD = 2'h0;
  localparam logic [1:0] IMM_CMP = 2'h1;
  localparam logic [2:0] G2_MISC = 3'h5;
  localparam logic [2:0] G2_STORE = 3'h6;
  localparam logic [2:0] G2_OUT = 3'h7;

  localparam logic [2:0] MISC_CMP = 3'h3;
  localparam logic [2:0] MISC_TST = 3'h4;
  localparam logic [2:0] MISC_PRELOAD = 3'h5;
  localparam logic [2:0] MISC_CARRY = 3'h6;
  localparam logic [2:0] MISC_CMPC = 3'h7;

  localparam logic [2:0] G3_IN = 3'h0;
  localparam logic [2:0] G3_FETCH = 3'h1;
  localparam logic [2:0] G3_ARITH = 3'h2;
  localparam logic [2:0] G3_LOGIC = 3'h4;
  localparam logic [2:0] G3_SHIFT = 3'h5;

  localparam logic [2:0] LG_NOT = 3'h0;
  localparam logic [2:0] LG_AND = 3'h1;
  localparam logic [2:0] LG_OR = 3'h2;
  localparam logic [2:0] LG_XOR = 3'h3;

  localparam logic [2:0] SH_RIGHT = 3'h6;
  localparam logic [2:0] SH_LEFT = 3'h7;
  localparam logic [1:0] SH_ROT = 2'h0;
  localparam logic [1:0] SH_ALT = 2'h1;
  localparam logic [1:0] SH_CARRY = 2'h2;
  localparam logic [1:0] SH_LOGIC = 2'h3;

  localparam logic [2:0] COND_ALWAYS = 3'h0;
  localparam logic [2:0] COND_NEVER = 3'h1;
  localparam logic [2:0] COND_VS = 3'h2;
  localparam logic [2:0] COND_VC = 3'h3;
  localparam logic [2:0] COND_ZS = 3'h4;
  localparam logic [2:0] COND_ZC = 3'h5;
  localparam logic [2:0] COND_CS = 3'h6;
  localparam logic [2:0] COND_CC = 3'h7;

  // ----------------------------------------------------------------
  // sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int STACK_DEPTH = 16;
  localparam int STACK_PTR_W = 4;
  localparam logic [8:0] REP_EXTRA = 9'h001;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [STACK_PTR_W-1:0] RESET_SP = 4'h0;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic RESET_RUN = 1'b1;

endpackage : soft_cpu_pkg

// ===== rtl/return_stack.sv
`timescale 1ns/10ps
`default_nettype none
module return_stack (
  input wire logic clock,
  input wire logic rstn,
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] push_data,
  output logic [15:0] top,
  output logic [soft_cpu_pkg::STACK_PTR_W-1:0] sp
);

  logic [15:0] entries [0:soft_cpu_pkg::STACK_DEPTH-1];
  logic [soft_cpu_pkg::STACK_PTR_W-1:0] sp_reg;
  logic [15:0] hold_reg;
  logic pending_reg;

  // pointer wraps at the depth, no overflow flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sp_reg <= soft_cpu_pkg::RESET_SP;
    end else if (push) begin
      sp_reg <= sp_reg + 4'h1;
    end else if (pop) begin
      sp_reg <= sp_reg - 4'h1;
    end
  end

  // pushed value (return address or register) parked here while the pointer moves, written one cycle later
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pending_reg <= 1'b0;
      hold_reg <= 16'h0000;
    end else begin
      pending_reg <= push;
      if (push) begin
        hold_reg <= push_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (pending_reg) begin
      entries[sp_reg] <= hold_reg;
    end
  end

  // the core never reads in the cycle after a push, so the late write is safe
  assign top = entries[sp_reg];
  assign sp = sp_reg;

endmodule : return_stack
`default_nettype wire

// ===== rtl/arith_unit.sv
`timescale 1ns/10ps
`default_nettype none
module arith_unit (
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic sub,
  input wire logic use_carry,
  input wire logic carry_in,
  output logic [15:0] sum,
  output logic carry_out,
  output logic overflow,
  output logic zero
);

  logic [15:0] b_eff;
  logic cin;
  logic [16:0] total;

  // carry reads as borrow after a subtract
  assign b_eff = sub ? ~b : b;
  assign cin = sub ? ~(use_carry & carry_in) : (use_carry & carry_in);
  assign total = {1'b0, a} + {1'b0, b_eff} + {16'h0000, cin};
  assign sum = total[15:0];
  assign carry_out = sub ? ~total[16] : total[16];
  assign overflow = (a[15] == b_eff[15]) & (sum[15] != a[15]);
  assign zero = (sum == 16'h0000);

endmodule : arith_unit
`default_nettype wire

// ===== rtl/soft_cpu_flow_io_decode.sv
`timescale 1ns/10ps
`default_nettype none
module soft_cpu_flow_io_decode (
  input wire logic clock,
  input wire logic rstn,
  // instruction port of the shared memory
  output logic [15:0] imem_addr,
  input wire logic [15:0] imem_rdata,
  // data port of the shared memory
  output logic [15:0] dmem_addr,
  output logic [15:0] dmem_wdata,
  output logic dmem_we,
  output logic dmem_re,
  input wire logic [15:0] dmem_rdata,
  // peripheral port bus
  output logic [6:0] port_addr_bus,
  output logic [15:0] port_wdata_bus,
  output logic port_write_strobe,
  output logic port_read_strobe,
  input wire logic [15:0] port_rdata_bus,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {st_fetch, st_exec, st_wait, st_take} cpu_state_type;

  cpu_state_type state_reg;
  cpu_state_type state_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [15:0] regs [0:15];
  logic flag_c_reg;
  logic flag_v_reg;
  logic flag_z_reg;
  logic flag_c_next;
  logic flag_v_next;
  logic flag_z_next;
  logic [7:0] high_reg;
  logic [7:0] high_next;
  logic high_valid_reg;
  logic high_valid_next;
  logic [8:0] rep_left_reg;
  logic [8:0] rep_left_next;
  logic [3:0] dest_reg;
  logic from_port_reg;
  logic run_reg;

  logic [15:0] instr;
  logic [3:0] ra;
  logic [3:0] rb;
  logic [15:0] a_val;
  logic [15:0] b_val;
  logic [15:0] pc_inc;
  logic [15:0] seq_pc;
  logic [7:0] const8;
  logic [15:0] imm16;
  logic [15:0] rel_off;
  logic [15:0] mem_addr;
  logic cond_ok;
  logic rf_we;
  logic [3:0] rf_waddr;
  logic [15:0] rf_wdata;
  logic push;
  logic pop;
  logic [15:0] push_data;
  logic [15:0] stack_top;
  logic [3:0] stack_ptr;
  logic do_store;
  logic do_load;
  logic do_out;
  logic do_in;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic alu_sub;
  logic alu_carry;
  logic [15:0] alu_sum;
  logic alu_c;
  logic alu_v;
  logic alu_z;

  function automatic logic cond_met(input logic [2:0] cond, input logic c,
                                    input logic v, input logic z);
    case (cond)
      soft_cpu_pkg::COND_ALWAYS: cond_met = 1'b1;
      soft_cpu_pkg::COND_NEVER: cond_met = 1'b0;
      soft_cpu_pkg::COND_VS: cond_met = v;
      soft_cpu_pkg::COND_VC: cond_met = ~v;
      soft_cpu_pkg::COND_ZS: cond_met = z;
      soft_cpu_pkg::COND_ZC: cond_met = ~z;
      soft_cpu_pkg::COND_CS: cond_met = c;
      default: cond_met = ~c;
    endcase
  endfunction : cond_met

  // ----------------------------------------------------------------
  // operand decode
  // ----------------------------------------------------------------
  assign instr = imem_rdata;
  assign ra = instr[soft_cpu_pkg::FLD_A_LSB +: 4];
  assign rb = instr[soft_cpu_pkg::FLD_B_LSB +: 4];
  assign a_val = regs[ra];
  assign b_val = regs[rb];
  assign pc_inc = pc_reg + 16'h0001;
  // pc stays put while a reissue is outstanding
  assign seq_pc = (rep_left_reg != 9'h000) ? pc_reg : pc_inc;
  assign const8 = instr[soft_cpu_pkg::FLD_CONST_LSB +: 8];
  assign imm16 = high_valid_reg ? {high_reg, const8} : {{8{const8[7]}}, const8};
  assign rel_off = {{7{instr[8]}}, instr[8:0]};
  assign mem_addr = b_val + {13'h0000, instr[soft_cpu_pkg::FLD_OFFSET_LSB +: 3]};
  assign cond_ok = cond_met(instr[soft_cpu_pkg::FLD_COND_LSB +: 3], flag_c_reg,
                            flag_v_reg, flag_z_reg);

  arith_unit u_arith (
    .a(alu_a),
    .b(alu_b),
    .sub(alu_sub),
    .use_carry(alu_carry),
    .carry_in(flag_c_reg),
    .sum(alu_sum),
    .carry_out(alu_c),
    .overflow(alu_v),
    .zero(alu_z)
  );

  return_stack u_stack (
    .clock(clock),
    .rstn(rstn),
    .push(push),
    .pop(pop),
    .push_data(push_data),
    .top(stack_top),
    .sp(stack_ptr)
  );

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    rf_we = 1'b0;
    rf_waddr = ra;
    rf_wdata = alu_sum;
    flag_c_next = flag_c_reg;
    flag_v_next = flag_v_reg;
    flag_z_next = flag_z_reg;
    high_next = high_reg;
    high_valid_next = high_valid_reg;
    rep_left_next = rep_left_reg;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_inc;
    do_store = 1'b0;
    do_load = 1'b0;
    do_out = 1'b0;
    do_in = 1'b0;
    alu_a = a_val;
    alu_b = b_val;
    alu_sub = 1'b0;
    alu_carry = 1'b0;
    case (state_reg)
      st_fetch: begin
        if (run_reg) begin
          state_next = st_exec;
        end
      end
      st_exec: begin
        state_next = st_fetch;
        pc_next = seq_pc;
        if (rep_left_reg != 9'h000) begin
          rep_left_next = rep_left_reg - 9'h001;
        end
        case (instr[15:14])
          soft_cpu_pkg::TYPE_CALL: begin
            push = 1'b1;
            pc_next = {2'b00, instr[13:0]};
          end
          soft_cpu_pkg::TYPE_FLOW: begin
            case (instr[13:12])
              soft_cpu_pkg::FLOW_JUMP: begin
                if (cond_ok) begin
                  pc_next = pc_inc + rel_off;
                end
              end
              soft_cpu_pkg::FLOW_RET: begin
                if (!instr[soft_cpu_pkg::FLD_LOOP_BIT]) begin
                  if (cond_ok) begin
                    pc_next = stack_top;
                    pop = 1'b1;
                  end
                end else if (cond_ok) begin
                  pc_next = stack_top;
                end else begin
                  pop = 1'b1;
                end
              end
              soft_cpu_pkg::FLOW_PUSH: begin
                if (instr[soft_cpu_pkg::FLD_REP_BIT]) begin
                  rep_left_next = {1'b0, instr[7:0]} + soft_cpu_pkg::REP_EXTRA;
                end else begin
                  push = 1'b1;
                  if (instr[soft_cpu_pkg::FLD_PUSH_REGISTER_BIT]) begin
                    push_data = a_val;
                  end
                end
              end
              default: begin
                rf_we = 1'b1;
                rf_wdata = imm16;
                high_valid_next = 1'b0;
              end
            endcase
          end
          soft_cpu_pkg::TYPE_IMM: begin
            if (!instr[13]) begin
              alu_b = imm16;
              alu_sub = (instr[13:12] == soft_cpu_pkg::IMM_CMP);
              high_valid_next = 1'b0;
              rf_we = (instr[13:12] == soft_cpu_pkg::IMM_ADD);
              flag_c_next = alu_c;
              flag_v_next = alu_v;
              flag_z_next = alu_z;
            end else begin
              case (instr[13:11])
                soft_cpu_pkg::G2_MISC: begin
                  case (instr[10:8])
                    soft_cpu_pkg::MISC_TST: flag_c_next = a_val[rb];
                    soft_cpu_pkg::MISC_PRELOAD: begin
                      high_next = instr[7:0];
                      high_valid_next = 1'b1;
                    end
                    soft_cpu_pkg::MISC_CARRY: flag_c_next = instr[4];
                    soft_cpu_pkg::MISC_CMP, soft_cpu_pkg::MISC_CMPC: begin
                      alu_sub = 1'b1;
                      alu_carry = instr[10:8] == soft_cpu_pkg::MISC_CMPC;
                      flag_c_next = alu_c;
                      flag_v_next = alu_v;
                      flag_z_next = alu_z;
                    end
                    default: begin
                    end
                  endcase
                end
                soft_cpu_pkg::G2_STORE: do_store = 1'b1;
                soft_cpu_pkg::G2_OUT: do_out = 1'b1;
                default: begin
                end
              endcase
            end
          end
          default: begin
            case (instr[13:11])
              soft_cpu_pkg::G3_IN: begin
                do_in = 1'b1;
                state_next = st_wait;
              end
              soft_cpu_pkg::G3_FETCH: begin
                do_load = 1'b1;
                state_next = st_wait;
              end
              soft_cpu_pkg::G3_ARITH: begin
                // op bits: carry, use A, subtract; without A it is a move, or a negate when subtract is set
                alu_a = instr[9] ? a_val : 16'h0000;
                alu_sub = instr[8];
                alu_carry = instr[10];
                rf_we = 1'b1;
                flag_c_next = alu_c;
                flag_v_next = alu_v;
                flag_z_next = alu_z;
              end
              soft_cpu_pkg::G3_LOGIC: begin
                rf_we = instr[10:8] <= soft_cpu_pkg::LG_XOR;
                case (instr[10:8])
                  soft_cpu_pkg::LG_NOT: rf_wdata = ~b_val;
                  soft_cpu_pkg::LG_AND: rf_wdata = a_val & b_val;
                  soft_cpu_pkg::LG_OR: rf_wdata = a_val | b_val;
                  default: rf_wdata = a_val ^ b_val;
                endcase
              end
              soft_cpu_pkg::G3_SHIFT: begin
                if (instr[10:8] == soft_cpu_pkg::SH_RIGHT) begin
                  rf_we = 1'b1;
                  flag_c_next = a_val[0];
                  case (instr[7:6])
                    soft_cpu_pkg::SH_ROT: rf_wdata = {a_val[0], a_val[15:1]};
                    soft_cpu_pkg::SH_ALT: rf_wdata = {a_val[15], a_val[15:1]};
                    soft_cpu_pkg::SH_CARRY: rf_wdata = {flag_c_reg, a_val[15:1]};
                    default: rf_wdata = {1'b0, a_val[15:1]};
                  endcase
                end else if (instr[10:8] == soft_cpu_pkg::SH_LEFT) begin
                  rf_we = 1'b1;
                  flag_c_next = a_val[15];
                  case (instr[7:6])
                    soft_cpu_pkg::SH_CARRY: rf_wdata = {a_val[14:0], flag_c_reg};
                    soft_cpu_pkg::SH_LOGIC: rf_wdata = {a_val[14:0], 1'b0};
                    default: rf_wdata = {a_val[14:0], a_val[15]};
                  endcase
                end
              end
              default: begin
              end
            endcase
          end
        endcase
      end
      st_wait: state_next = st_take;
      st_take: begin
        rf_we = 1'b1;
        rf_waddr = dest_reg;
        rf_wdata = from_port_reg ? port_rdata_bus : dmem_rdata;
        state_next = st_fetch;
      end
      default: state_next = st_fetch;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= st_fetch;
      pc_reg <= soft_cpu_pkg::RESET_PC;
      rep_left_reg <= 9'h000;
      high_reg <= 8'h00;
      high_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      rep_left_reg <= rep_left_next;
      high_reg <= high_next;
      high_valid_reg <= high_valid_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      flag_c_reg <= 1'b0;
      flag_v_reg <= 1'b0;
      flag_z_reg <= 1'b0;
    end else begin
      flag_c_reg <= flag_c_next;
      flag_v_reg <= flag_v_next;
      flag_z_reg <= flag_z_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 16'h0000;
      end
    end else if (rf_we) begin
      regs[rf_waddr] <= rf_wdata;
    end
  end

  // ----------------------------------------------------------------
  // memory and port buses
  // ----------------------------------------------------------------
  // fetch runs on its own port off the pc flop, data traffic never blocks it
  assign imem_addr = pc_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      dmem_addr <= 16'h0000;
      dmem_wdata <= 16'h0000;
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      dest_reg <= 4'h0;
      from_port_reg <= 1'b0;
    end else begin
      dmem_we <= do_store;
      dmem_re <= do_load;
      if (do_store || do_load) begin
        dmem_addr <= mem_addr;
        dmem_wdata <= a_val;
      end
      if (do_load || do_in) begin
        dest_reg <= ra;
        from_port_reg <= do_in;
      end
    end
  end

  // read strobe spans the wait and take cycles so slow ports settle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      port_addr_bus <= 7'h00;
      port_wdata_bus <= 16'h0000;
      port_write_strobe <= 1'b0;
      port_read_strobe <= 1'b0;
    end else begin
      port_write_strobe <= do_out;
      port_read_strobe <= do_in | (port_read_strobe & (state_reg == st_wait));
      if (do_out || do_in) begin
        port_addr_bus <= instr[soft_cpu_pkg::FLD_PORT_LSB +: 7];
      end
      if (do_out) begin
        port_wdata_bus <= a_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      run_reg <= soft_cpu_pkg::RESET_RUN;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != soft_cpu_pkg::ADDR_CTRL) &
                 (paddr != soft_cpu_pkg::ADDR_STATUS);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          soft_cpu_pkg::ADDR_CTRL: prdata <= {31'h00000000, run_reg};
          soft_cpu_pkg::ADDR_STATUS: prdata <= {9'h000, flag_c_reg, flag_v_reg, flag_z_reg,
                                                stack_ptr, pc_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (psel && penable && pready && pwrite && (paddr == soft_cpu_pkg::ADDR_CTRL)) begin
        run_reg <= pwdata[soft_cpu_pkg::CTRL_RUN_BIT];
      end
    end
  end

endmodule : soft_cpu_flow_io_decode
`default_nettype wire

// ===== tb/soft_cpu_flow_io_decode_checker.sv
`timescale 1ns/10ps
`default_nettype none
module soft_cpu_flow_io_decode_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] imem_addr,
  input wire logic dmem_we,
  input wire logic dmem_re,
  input wire logic [6:0] port_addr_bus,
  input wire logic port_write_strobe,
  input wire logic port_read_strobe,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_wr; port_write_strobe |=> !port_write_strobe; endproperty
  a_wr: assert property (p_wr) else $error("write strobe too long");
  property p_rd; $rose(port_read_strobe) |=> port_read_strobe ##1 !port_read_strobe; endproperty
  a_rd: assert property (p_rd) else $error("read strobe not two cycles");
  property p_rda; $rose(port_read_strobe) |=> $stable(port_addr_bus); endproperty
  a_rda: assert property (p_rda) else $error("port address moved");
  property p_we; dmem_we |=> !dmem_we; endproperty
  a_we: assert property (p_we) else $error("store strobe too long");
  property p_re; dmem_re |=> !dmem_re; endproperty
  a_re: assert property (p_re) else $error("load strobe too long");
  property p_rst; $rose(rstn) |-> imem_addr == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("fetch not from zero");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04); endproperty
  a_err: assert property (p_err) else $error("bad slave error");
endmodule : soft_cpu_flow_io_decode_checker
bind soft_cpu_flow_io_decode soft_cpu_flow_io_decode_checker u_chk (.clock, .rstn,
  .imem_addr, .dmem_we, .dmem_re, .port_addr_bus, .port_write_strobe, .port_read_strobe,
  .paddr, .psel, .penable, .pready, .pslverr);
`default_nettype wire

// ===== tb/mem_port_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_port_model (
  input wire logic clock,
  input wire logic [15:0] imem_addr,
  output logic [15:0] imem_rdata,
  input wire logic [15:0] dmem_addr,
  input wire logic [15:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic dmem_re,
  output logic [15:0] dmem_rdata,
  input wire logic [6:0] port_addr_bus,
  input wire logic [15:0] port_wdata_bus,
  input wire logic port_write_strobe,
  input wire logic port_read_strobe,
  output logic [15:0] port_rdata_bus
);
  logic [15:0] mem [0:65535];
  logic [15:0] pval [0:127] = '{default: 16'h0000};
  logic [7:0] pcnt [0:127] = '{default: 8'h00};
  always @(posedge clock) begin
    imem_rdata <= mem[imem_addr];
    dmem_rdata <= dmem_re ? mem[dmem_addr] : ~dmem_rdata;
    if (dmem_we) mem[dmem_addr] <= dmem_wdata;
    if (port_write_strobe) begin
      pval[port_addr_bus] <= port_wdata_bus;
      pcnt[port_addr_bus] <= pcnt[port_addr_bus] + 8'h01;
    end
  end
  // idle bus shows the inverse so a stale sample is caught
  assign port_rdata_bus = port_read_strobe ? {9'h14A, port_addr_bus} :
                          ~{9'h14A, port_addr_bus};
endmodule : mem_port_model
`default_nettype wire

// ===== tb/soft_cpu_flow_io_decode_bench.sv
`timescale 1ns/10ps
`default_nettype none
module soft_cpu_flow_io_decode_bench;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] imem_addr, imem_rdata, dmem_addr, dmem_wdata, dmem_rdata;
  logic [15:0] port_wdata_bus, port_rdata_bus;
  logic dmem_we, dmem_re, port_write_strobe, port_read_strobe;
  logic [6:0] port_addr_bus;
  int error_cnt = 0, n_tests = 0, i;
  logic [31:0] prog [30] = '{32'h0000_7851, 32'h0001_B831, 32'h0002_AD12, 32'h0003_7342,
    32'h0004_7403, 32'h0005_B532, 32'h0006_CD34, 32'h0007_B844, 32'h0008_C095,
    32'h0009_B855, 32'h000A_0020, 32'h000B_4801, 32'h000C_B871, 32'h000D_4A01,
    32'h000E_B881, 32'h000F_6801, 32'h0010_B8A1, 32'h0011_7036, 32'h0012_6000,
    32'h0013_B8B6, 32'h0014_8FF6, 32'h0015_5B00, 32'h0016_71B7, 32'h0017_AC27,
    32'h0018_6407, 32'h0019_5000, 32'h001A_B881, 32'h001B_41FF, 32'h0020_B862,
    32'h0021_5000};
  logic [31:0] rows [8] = '{32'h0301_FF85,
    32'h0401_1234,
    32'h0501_A509,
    32'h0601_1234,
    32'h0701_FF85, 32'h0800_0000,
    32'h0A03_FF85,
    32'h0B03_0001};
  soft_cpu_flow_io_decode u_dut (.clock, .rstn, .imem_addr, .imem_rdata, .dmem_addr,
    .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .port_addr_bus, .port_wdata_bus,
    .port_write_strobe, .port_read_strobe, .port_rdata_bus, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr);
  mem_port_model u_mem (.clock, .imem_addr, .imem_rdata, .dmem_addr, .dmem_wdata, .dmem_we,
    .dmem_re, .dmem_rdata, .port_addr_bus, .port_wdata_bus, .port_write_strobe,
    .port_read_strobe, .port_rdata_bus);
  always #2 clock = ~clock;
  task conclude;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("mismatch t=%0t apb timeout", $time);
      conclude;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never redrives psel in this time step
    @(posedge clock);
  endtask : apb
  task run_to_end;
    for (i = 0; i < 600 && imem_addr !== 16'h001B; i++) @(posedge clock);
    if (i == 600) begin
      error_cnt++;
      $display("mismatch t=%0t run timeout", $time);
      conclude;
    end
    repeat (4) @(posedge clock);
  endtask : run_to_end
  initial begin
    for (i = 0; i < 30; i++) u_mem.mem[prog[i][31:16]] = prog[i][15:0];
    repeat (8) @(posedge clock);
    chk(imem_addr, 32'h0);
    rstn <= 1'b1;
    run_to_end;
    for (i = 0; i < 8; i++)
      chk({u_mem.pcnt[rows[i][30:24]], u_mem.pval[rows[i][30:24]]}, rows[i][23:0]);
    chk(u_mem.mem[16'h0045], 32'h1234);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0010_001B);
    apb(1'b0, 8'h08, 32'h0); chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h00, 32'h0); apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0);
    // mid-run reset of a halted core: it must restart from zero with clean state
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    chk(imem_addr, 32'h0);
    rstn <= 1'b1;
    run_to_end;
    chk({u_mem.pcnt[10], u_mem.pval[10]}, 32'h0006_FF85);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0010_001B);
    conclude;
  end
endmodule : soft_cpu_flow_io_decode_bench
`default_nettype wire
